// ### cfgrom_map.sv
// config-rom window mapping and posted-write failure capture registers
//
// Operation
// - window quadlet read maps to base plus offset
// - software writes base in bits 31..10
// - base bits 9..0 always read zero
// - failed posted write loads capture registers
// - low capture holds offset bits 31..0
// - high capture bits 15..0 hold offset top
// - requester bus and node in upper half
// - bus reset leaves base alone unless valid
`default_nettype none
module cfgrom_map
   import cfgrom_pkg::*;
(
   // clock and reset
   input  wire logic        MCLK,
   input  wire logic        RST,
   // avalon-mm slave
   input  wire logic [7:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   input  wire logic [3:0]  AVS_BYTEENABLE,
   output logic      [31:0] AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   // read requests from the 1394 side
   input  wire logic        RD_REQ_VALID,
   input  wire rd_req_t     RD_REQ,
   output logic             ROM_RD_VALID,
   output logic      [31:0] ROM_RD_ADDR,
   output logic             ROM_RD_MISS,
   // link events
   input  wire logic        BUS_RESET,
   input  wire logic        FAIL_VALID,
   input  wire fail_info_t  FAIL_INFO,
   // status
   output logic             ROM_IMAGE_VALID
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] be_merge(input logic [31:0] old_val,
                                            input logic [31:0] new_val,
                                            input logic [3:0]  be);
      logic [31:0] res;
      res = old_val;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = new_val[i*8 +: 8];
         end
      end
      return res;
   endfunction : be_merge

   function automatic logic in_rom_window(input logic [47:0] off);
      return (off >= ROM_WIN_FIRST) && (off <= ROM_WIN_LAST);
   endfunction : in_rom_window

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   bus_state_t  bus_state;
   bus_state_t  next_bus_state;
   logic        next_waitreq;
   logic [31:0] next_readdata;

   logic [31:0] rom_window_host_base;
   logic [31:0] next_rom_window_host_base;
   logic [31:0] base_shadow;
   logic [31:0] next_base_shadow;
   logic        rom_image_valid;
   logic        next_rom_image_valid;
   logic        capture_seen;
   logic        next_capture_seen;

   logic        next_rd_valid;
   logic [31:0] next_rd_addr;
   logic        next_rd_miss;

   logic [31:0] failed_offset_low;
   logic [31:0] failed_offset_high;

   logic        bus_req;
   logic        wr_take;
   logic [31:0] rd_mux;

   assign bus_req = AVS_READ || AVS_WRITE;
   // a write takes effect on the edge where the master sees waitrequest low
   assign wr_take = AVS_WRITE && (bus_state == BUS_ACK);

   // ----------------------------------------------------------------
   // read data selection
   // ----------------------------------------------------------------
   always_comb begin
      case (AVS_ADDRESS)
         OFF_ROM_BASE:  rd_mux = rom_window_host_base & BASE_MASK;
         OFF_FAIL_LOW:  rd_mux = failed_offset_low;
         OFF_FAIL_HIGH: rd_mux = failed_offset_high;
         OFF_CONTROL:   rd_mux = {rom_image_valid, 31'h0000_0000};
         OFF_STATUS:    rd_mux = {31'h0000_0000, capture_seen};
         default:       rd_mux = 32'h0000_0000;
      endcase
   end

   // ----------------------------------------------------------------
   // avalon slave: one wait cycle on every access
   // ----------------------------------------------------------------
   always_comb begin
      next_bus_state = bus_state;
      next_waitreq   = 1'b1;
      next_readdata  = AVS_READDATA;
      case (bus_state)
         BUS_IDLE: begin
            if (bus_req) begin
               next_bus_state = BUS_ACK;
               next_waitreq   = 1'b0;
               // a write leaves the last read data standing
               if (AVS_READ) begin
                  next_readdata = rd_mux;
               end
            end
         end
         BUS_ACK: begin
            next_bus_state = BUS_IDLE;
         end
         default: begin
            next_bus_state = BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         bus_state       <= BUS_IDLE;
         AVS_WAITREQUEST <= 1'b1;
         AVS_READDATA    <= 32'h0000_0000;
      end else begin
         bus_state       <= next_bus_state;
         AVS_WAITREQUEST <= next_waitreq;
         AVS_READDATA    <= next_readdata;
      end
   end

   // ----------------------------------------------------------------
   // mapping base, control and status
   // ----------------------------------------------------------------
   // writes land in a shadow; with the image valid the live base only
   // follows the shadow at a bus reset, so remote reads see a stable map
   always_comb begin
      next_base_shadow          = base_shadow;
      next_rom_window_host_base = rom_window_host_base;
      next_rom_image_valid      = rom_image_valid;
      next_capture_seen         = capture_seen;
      if (wr_take && AVS_ADDRESS == OFF_ROM_BASE) begin
         next_base_shadow = be_merge(base_shadow, AVS_WRITEDATA, AVS_BYTEENABLE) & BASE_MASK;
         if (!rom_image_valid) begin
            next_rom_window_host_base = next_base_shadow;
         end
      end
      if (BUS_RESET && rom_image_valid) begin
         next_rom_window_host_base = next_base_shadow;
      end
      if (wr_take && AVS_ADDRESS == OFF_CONTROL && AVS_BYTEENABLE[3]) begin
         next_rom_image_valid = AVS_WRITEDATA[CTRL_VALID_BIT];
      end
      if (wr_take && AVS_ADDRESS == OFF_STATUS && AVS_BYTEENABLE[0]
          && AVS_WRITEDATA[STAT_SEEN_BIT]) begin
         next_capture_seen = 1'b0;
      end
      // a failure in the clearing cycle still leaves the flag set
      if (FAIL_VALID) begin
         next_capture_seen = 1'b1;
      end
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         base_shadow          <= ROM_BASE_RST;
         rom_window_host_base <= ROM_BASE_RST;
         rom_image_valid      <= 1'b0;
         capture_seen         <= 1'b0;
         ROM_IMAGE_VALID      <= 1'b0;
      end else begin
         base_shadow          <= next_base_shadow;
         rom_window_host_base <= next_rom_window_host_base;
         rom_image_valid      <= next_rom_image_valid;
         capture_seen         <= next_capture_seen;
         ROM_IMAGE_VALID      <= next_rom_image_valid;
      end
   end

   // ----------------------------------------------------------------
   // remote read mapping
   // ----------------------------------------------------------------
   // only quadlet reads are mapped; block reads take another path
   always_comb begin
      next_rd_valid = 1'b0;
      next_rd_miss  = 1'b0;
      next_rd_addr  = ROM_RD_ADDR;
      if (RD_REQ_VALID) begin
         if (RD_REQ.quadlet && in_rom_window(RD_REQ.offset)) begin
            next_rd_valid = 1'b1;
            next_rd_addr  = rom_window_host_base + {22'h00_0000, RD_REQ.offset[9:0]};
         end else begin
            next_rd_miss = 1'b1;
         end
      end
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         ROM_RD_VALID <= 1'b0;
         ROM_RD_MISS  <= 1'b0;
         ROM_RD_ADDR  <= 32'h0000_0000;
      end else begin
         ROM_RD_VALID <= next_rd_valid;
         ROM_RD_MISS  <= next_rd_miss;
         ROM_RD_ADDR  <= next_rd_addr;
      end
   end

   // ----------------------------------------------------------------
   // failure capture
   // ----------------------------------------------------------------
   fail_capture u_fail_capture (
      .clk         (MCLK),
      .rst         (RST),
      .fail_valid  (FAIL_VALID),
      .fail_info   (FAIL_INFO),
      .offset_low  (failed_offset_low),
      .source_high (failed_offset_high)
   );

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);

   sequence rom_hit_s;
      RD_REQ_VALID && RD_REQ.quadlet && in_rom_window(RD_REQ.offset);
   endsequence

   sequence base_read_s;
      AVS_READ && AVS_ADDRESS == OFF_ROM_BASE && bus_state == BUS_IDLE;
   endsequence

   sequence held_answer_s;
      !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
   endsequence

   sequence taken_read_s(logic [7:0] a);
      AVS_READ && AVS_ADDRESS == a && bus_state == BUS_IDLE;
   endsequence

   sequence taken_write_s;
      AVS_WRITE && bus_state == BUS_IDLE;
   endsequence

   rom_map_addr_a: assert property (rom_hit_s |=> ROM_RD_VALID && !ROM_RD_MISS
                                    && ROM_RD_ADDR == $past(rom_window_host_base)
                                       + {22'h00_0000, $past(RD_REQ.offset[9:0])})
      else $error("mapped host address wrong");
   rom_miss_a: assert property (RD_REQ_VALID && !in_rom_window(RD_REQ.offset) |=> ROM_RD_MISS && !ROM_RD_VALID)
      else $error("out of window read was mapped");
   base_low_zero_a: assert property (base_read_s |=> AVS_READDATA[9:0] == 10'h000 && !AVS_WAITREQUEST)
      else $error("base low bits not zero on read");
   base_write_a: assert property (wr_take && AVS_ADDRESS == OFF_ROM_BASE && AVS_BYTEENABLE == 4'hf
                                  && !rom_image_valid |=> rom_window_host_base[31:10] == $past(AVS_WRITEDATA[31:10]))
      else $error("base write not applied");
   base_hold_a: assert property (BUS_RESET && !rom_image_valid && !wr_take |=> $stable(rom_window_host_base))
      else $error("base changed on bus reset while image invalid");
   fail_seen_a: assert property (FAIL_VALID |=> capture_seen ##1 capture_seen || $past(wr_take))
      else $error("failure not flagged");
   bus_answer_a: assert property (bus_req && bus_state == BUS_IDLE |=> held_answer_s)
      else $error("slave answer not exactly one cycle");

   low_read_a: assert property (taken_read_s(OFF_FAIL_LOW)
                                |=> AVS_READDATA == $past(failed_offset_low))
      else $error("low capture read back wrong");
   high_read_a: assert property (taken_read_s(OFF_FAIL_HIGH)
                                 |=> AVS_READDATA == $past(failed_offset_high))
      else $error("high capture read back wrong");
   rom_quiet_a: assert property (!RD_REQ_VALID |=> !ROM_RD_VALID && !ROM_RD_MISS)
      else $error("mapping answer without a request");
   rom_addr_hold_a: assert property (!(RD_REQ_VALID && RD_REQ.quadlet && in_rom_window(RD_REQ.offset))
                                     |=> $stable(ROM_RD_ADDR))
      else $error("host address moved without a hit");
   shadow_hold_a: assert property (wr_take && AVS_ADDRESS == OFF_ROM_BASE && rom_image_valid && !BUS_RESET
                                   |=> $stable(rom_window_host_base))
      else $error("live base moved on a write while image valid");
   seen_clear_a: assert property (wr_take && AVS_ADDRESS == OFF_STATUS && AVS_BYTEENABLE[0]
                                  && AVS_WRITEDATA[STAT_SEEN_BIT] && !FAIL_VALID |=> !capture_seen)
      else $error("status flag not cleared");
   write_keeps_data_a: assert property (taken_write_s |=> $stable(AVS_READDATA))
      else $error("read data changed on a write");
   image_out_a: assert property (wr_take && AVS_ADDRESS == OFF_CONTROL && AVS_BYTEENABLE[3]
                                 |=> ROM_IMAGE_VALID == $past(AVS_WRITEDATA[CTRL_VALID_BIT]))
      else $error("image valid output not following control write");

endmodule : cfgrom_map
`default_nettype wire

// ### cfgrom_pkg.sv
// package: register map, field layout and carrier types for the config-rom map block
`default_nettype none
package cfgrom_pkg;

   // ----------------------------------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0]  OFF_ROM_BASE   = 8'h34;
   localparam logic [7:0]  OFF_FAIL_LOW   = 8'h38;
   localparam logic [7:0]  OFF_FAIL_HIGH  = 8'h3c;
   localparam logic [7:0]  OFF_CONTROL    = 8'h44;
   localparam logic [7:0]  OFF_STATUS     = 8'h48;

   // ----------------------------------------------------------------
   // fields and reset values
   // ----------------------------------------------------------------
   localparam int          BASE_LSB       = 10;
   localparam logic [31:0] BASE_MASK      = 32'hffff_fc00;
   localparam logic [31:0] ROM_BASE_RST   = 32'h0000_0000;
   localparam logic [31:0] CAPTURE_RST    = 32'h0000_0000;
   localparam int          CTRL_VALID_BIT = 31;
   localparam int          STAT_SEEN_BIT  = 0;
   localparam int          ID_NODE_LSB    = 16;
   localparam int          ID_BUS_LSB     = 22;

   // ----------------------------------------------------------------
   // configuration rom window on the 1394 side
   // ----------------------------------------------------------------
   localparam logic [47:0] ROM_WIN_FIRST  = 48'hffff_f000_0400;
   localparam logic [47:0] ROM_WIN_LAST   = 48'hffff_f000_07ff;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        quadlet;
      logic [47:0] offset;
   } rd_req_t;

   typedef struct packed {
      logic [9:0]  bus_num;
      logic [5:0]  node_num;
      logic [47:0] offset;
   } fail_info_t;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_ACK  = 2'b01
   } bus_state_t;

endpackage : cfgrom_pkg
`default_nettype wire

// ### fail_capture.sv
// failed posted-write capture pair
`default_nettype none
module fail_capture
   import cfgrom_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // failure event
   input  wire logic        fail_valid,
   input  wire fail_info_t  fail_info,
   // captured words
   output var  logic [31:0] offset_low,
   output var  logic [31:0] source_high
);

   logic [31:0] next_offset_low;
   logic [31:0] next_source_high;

   // ----------------------------------------------------------------
   // capture
   // ----------------------------------------------------------------
   // both words load on the same edge, so a read never mixes failures
   always_comb begin
      next_offset_low  = offset_low;
      next_source_high = source_high;
      if (fail_valid) begin
         next_offset_low  = fail_info.offset[31:0];
         next_source_high = {fail_info.bus_num, fail_info.node_num,
                             fail_info.offset[47:32]};
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         offset_low  <= CAPTURE_RST;
         source_high <= CAPTURE_RST;
      end else begin
         offset_low  <= next_offset_low;
         source_high <= next_source_high;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   capture_low_a: assert property (fail_valid |=> offset_low == $past(fail_info.offset[31:0]))
      else $error("low capture does not hold failed offset");
   capture_high_a: assert property (fail_valid |=> source_high[15:0] == $past(fail_info.offset[47:32]))
      else $error("high capture does not hold upper offset");
   capture_id_a: assert property (fail_valid |=> source_high[31:22] == $past(fail_info.bus_num)
                                  && source_high[21:16] == $past(fail_info.node_num))
      else $error("requester id misplaced in high capture");
   capture_pair_a: assert property (!fail_valid |=> $stable(offset_low) && $stable(source_high))
      else $error("capture pair changed without a failure");

endmodule : fail_capture
`default_nettype wire

// ### remote_node.sv
// remote 1394 node model: read requests, posted-write failures and bus resets
`default_nettype none
module remote_node
   import cfgrom_pkg::*;
(
   // clock
   input  wire logic       clk,
   // requests toward the block
   output var  logic       rd_valid,
   output var  rd_req_t    rd_req,
   output var  logic       bus_reset,
   output var  logic       fail_valid,
   output var  fail_info_t fail_info
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      rd_valid   = 1'b0;
      rd_req     = '0;
      bus_reset  = 1'b0;
      fail_valid = 1'b0;
      fail_info  = '0;
   end

   // ----------------------------------------------------------------
   // one-cycle requests
   // ----------------------------------------------------------------
   // released fields are inverted so a stale request never looks valid
   task read_req(input logic q, input logic [47:0] off);
      @(posedge clk);
      rd_valid <= 1'b1;
      rd_req   <= {q, off};
      @(posedge clk);
      rd_valid <= 1'b0;
      rd_req   <= ~{q, off};
   endtask : read_req

   task fail(input logic [63:0] info);
      @(posedge clk);
      fail_valid <= 1'b1;
      fail_info  <= info;
      @(posedge clk);
      fail_valid <= 1'b0;
      fail_info  <= ~info;
   endtask : fail

   task bus_rst();
      @(posedge clk);
      bus_reset <= 1'b1;
      @(posedge clk);
      bus_reset <= 1'b0;
   endtask : bus_rst
endmodule : remote_node
`default_nettype wire

// ### tb.sv
// self-checking bench for the config-rom map block
`default_nettype none
module tb
   import cfgrom_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk, rst, rd, wr, waitreq, rv, rom_valid, rom_miss, img, brst, fv;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata, rom_addr, lfsr, base, shadow, q, v;
   logic [3:0]  be;
   logic [63:0] info;
   logic [47:0] off;
   logic        valid;
   rd_req_t     rq;
   fail_info_t  fi;
   int          errors, total_checks, i;

   cfgrom_map dut (.MCLK(mclk), .RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
      .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
      .RD_REQ_VALID(rv), .RD_REQ(rq), .ROM_RD_VALID(rom_valid), .ROM_RD_ADDR(rom_addr),
      .ROM_RD_MISS(rom_miss), .BUS_RESET(brst), .FAIL_VALID(fv), .FAIL_INFO(fi), .ROM_IMAGE_VALID(img));
   remote_node node (.clk(mclk), .rd_valid(rv), .rd_req(rq), .bus_reset(brst), .fail_valid(fv),
      .fail_info(fi));

   initial mclk = 1'b0;
   always #25 mclk = ~mclk;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] next_rand();
      lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04c1_1db7 : 32'h0000_0000);
      return lfsr;
   endfunction : next_rand

   task finish_test();
      if (errors == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test

   task chk(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
      int n;
      @(posedge mclk);
      addr  <= a;
      wdata <= d;
      be    <= b;
      wr    <= w;
      rd    <= !w;
      for (n = 0; n < 20; n++) begin
         @(posedge mclk);
         if (waitreq === 1'b0) break;
      end
      if (n == 20) begin
         errors++;
         finish_test();
      end
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : bus

   task rd_chk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000, 4'hf);
      chk(q, exp);
   endtask : rd_chk

   // shadow takes every write; live base follows at once only while image not valid
   task base_wr(input logic [31:0] d, input logic [3:0] b);
      bus(1'b1, OFF_ROM_BASE, d, b);
      for (int k = 0; k < 4; k++)
         if (b[k]) shadow[8*k +: 8] = d[8*k +: 8];
      shadow = shadow & BASE_MASK;
      if (!valid) base = shadow;
   endtask : base_wr

   task remote(input logic qd, input logic [47:0] o);
      logic hit;
      node.read_req(qd, o);
      @(negedge mclk);
      hit = qd && o >= ROM_WIN_FIRST && o <= ROM_WIN_LAST;
      chk(rom_valid, hit);
      chk(rom_miss, !hit);
      if (hit) chk(rom_addr, base + {22'h0, o[9:0]});
   endtask : remote

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      lfsr = 32'h96e3da6f;
      errors = 0;
      total_checks = 0;
      {rd, wr, addr, wdata, be} = '0;
      base = ROM_BASE_RST;
      shadow = ROM_BASE_RST;
      valid = 1'b0;
      rst = 1'b1;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      @(negedge mclk);
      chk(waitreq, 1'b1);
      chk(img, 1'b0);
      rd_chk(OFF_ROM_BASE, ROM_BASE_RST);
      rd_chk(OFF_CONTROL, 32'h0000_0000);
      rd_chk(OFF_FAIL_LOW, CAPTURE_RST);
      rd_chk(OFF_FAIL_HIGH, CAPTURE_RST);
      // base write and read back, full and partial lanes, low bits held at zero
      base_wr(next_rand(), 4'hf);
      rd_chk(OFF_ROM_BASE, base);
      base_wr(32'hffff_ffff, 4'b0001);
      rd_chk(OFF_ROM_BASE, base);
      base_wr(next_rand(), 4'b0110);
      rd_chk(OFF_ROM_BASE, base);
      // window edges, one step outside, random in or just below the window, random high offsets, both request kinds
      for (i = 0; i < 12; i++) begin
         v = next_rand();
         case (i % 6)
            0: off = ROM_WIN_FIRST;
            1: off = ROM_WIN_LAST;
            2: off = ROM_WIN_FIRST - 48'h1;
            3: off = ROM_WIN_LAST + 48'h1;
            4: off = ROM_WIN_FIRST + {38'h0, v[9:0]} - 48'h400 * v[10];
            default: off = {16'hffff, v};
         endcase
         remote(i < 6, off);
      end
      // unmapped place reads zero and ignores writes
      bus(1'b1, 8'h40, next_rand(), 4'hf);
      rd_chk(8'h40, 32'h0000_0000);
      // failures, two in a row each time: the later one must be held whole
      for (i = 0; i < 3; i++) begin
         node.fail({next_rand(), next_rand()});
         info = {next_rand(), next_rand()};
         node.fail(info);
         rd_chk(OFF_FAIL_LOW, info[31:0]);
         rd_chk(OFF_FAIL_HIGH, {info[63:54], info[53:48], info[47:32]});
         rd_chk(OFF_STATUS, 32'h0000_0001);
         bus(1'b1, OFF_STATUS, 32'h0000_0001, 4'hf);
         rd_chk(OFF_STATUS, 32'h0000_0000);
      end
      // bus reset with image not valid leaves the base alone
      node.bus_rst();
      rd_chk(OFF_ROM_BASE, base);
      bus(1'b1, OFF_CONTROL, 32'h8000_0000, 4'hf);
      valid = 1'b1;
      rd_chk(OFF_CONTROL, 32'h8000_0000);
      chk(img, 1'b1);
      base_wr(next_rand(), 4'hf);
      rd_chk(OFF_ROM_BASE, base);
      remote(1'b1, ROM_WIN_LAST);
      node.bus_rst();
      base = shadow;
      rd_chk(OFF_ROM_BASE, base);
      remote(1'b1, ROM_WIN_FIRST + 48'h2c);
      // shadow ahead of the live base, image then cleared: a bus reset must not load it
      base_wr(next_rand(), 4'hf);
      bus(1'b1, OFF_CONTROL, 32'h0000_0000, 4'hf);
      valid = 1'b0;
      node.bus_rst();
      rd_chk(OFF_ROM_BASE, base);
      remote(1'b1, ROM_WIN_FIRST + 48'h3fc);
      finish_test();
   end
endmodule : tb
`default_nettype wire
